// ### verilog/ims_pkg.sv
// shared constants of the two-wire master sequencer
package ims_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [2:0] IMS_OFF_CTRL_A = 3'h0;
  localparam logic [2:0] IMS_OFF_CTRL_B = 3'h1;
  localparam logic [2:0] IMS_OFF_STATUS = 3'h2;
  localparam logic [2:0] IMS_OFF_BUF    = 3'h3;
  localparam logic [2:0] IMS_OFF_RATE   = 3'h4;
  localparam logic [2:0] IMS_OFF_FLAGS  = 3'h5;
  localparam logic [2:0] IMS_OFF_FWLINE = 3'h6;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int IMS_A_ENABLE  = 5;
  localparam int IMS_B_START   = 0;
  localparam int IMS_B_RESTART = 1;
  localparam int IMS_B_STOP    = 2;
  localparam int IMS_B_RECV    = 3;
  localparam int IMS_B_ACKSEND = 4;
  localparam int IMS_B_ACKVAL  = 5;
  localparam int IMS_B_ACK_RECEIVED_STATUS = 6;
  localparam int IMS_S_FULL    = 0;
  localparam int IMS_S_START   = 3;
  localparam int IMS_S_STOP    = 4;
  localparam int IMS_F_EVENT   = 0;
  localparam int IMS_F_BUSCOL  = 1;
  localparam int IMS_F_WRITE_COLLISION    = 2;
  // ------------------------------------------------------------
  // modes and reset values
  // ------------------------------------------------------------
  localparam logic [3:0] IMS_MODE_HW   = 4'h8;
  localparam logic [3:0] IMS_MODE_FW   = 4'hB;
  localparam logic [7:0] IMS_RST_BYTE  = 8'h00;
  localparam logic [7:0] IMS_RST_RATE  = 8'h09;
  localparam logic [3:0] IMS_BITS_BYTE = 4'h8;
  typedef enum logic [3:0] {
    S_IDLE, S_SA, S_SB, S_RA, S_RB, S_RC, S_TL, S_TH,
    S_RL, S_RH, S_AL, S_AH, S_PA, S_PB, S_PC
  } ims_state_t;
endpackage

// ### verilog/ims_master_seq.sv
// master sequencer of a two-wire open-drain serial port
// Functional notes
// - event flag on start, stop, byte, ack, restart
// - no queueing; early buffer write sets write_collision
// - master masks bus detect; flag on completion
// - seen bits cleared by reset or disable
// - firmware mode only detects start and stop
// - first byte is address plus rw bit
// - eight bit units, ack after each byte
// - counter halts until scl seen high, reloads
// - buffer write while busy ignored, sets write_collision
// - control b low bits locked during start
// - start: wait period, sda low, wait, done
// - start aborted on low lines, collision
// - restart sequence of released and held lines
// - restart sets start seen, flag after timeout
// - restart while busy has no effect
// - restart collision on sda low or scl low
// - transmit: buffer full, bits after scl falls
// - eighth fall clears full, releases sda
// - ninth clock captures slave ack status
// - after ninth clock flag, scl held low
// - lines driven low only, open drain
// - stop sequence sets stop seen, then flag
// - sda low on sent one is collision
// - receive eight bits, load buffer, flag
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
module ims_master_seq
  import ims_pkg::*;
(
  // clock, reset, enable
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic       ce_in,
  // register port
  input  wire logic [2:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // bus lines
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            scl_out,
  output logic            scl_oe_out,
  output logic            sda_out,
  output logic            sda_oe_out
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  ims_state_t  state;
  logic [7:0]  ctrl_a, ctrl_b, buffer, rate, shreg, cnt;
  logic [1:0]  fw_lines;
  logic [3:0]  bitcnt;
  logic [4:0]  p_clr;
  logic        buffer_full, start_seen, stop_seen, ack_stat;
  logic        port_event_flag, collision_flag, write_collision;
  logic        scl_m, scl_s, sda_m, sda_s, sda_d, wait_hi, tx_go;
  logic        p_evt, p_bcl, p_bfclr, p_rxload, p_sseen, p_pseen;
  logic        hw_mode, fw_mode, tick, rise, coll, busy, buf_wr, fw_edge;

  assign hw_mode = ctrl_a[IMS_A_ENABLE] && ctrl_a[3:0] == IMS_MODE_HW;
  assign fw_mode = ctrl_a[IMS_A_ENABLE] && ctrl_a[3:0] == IMS_MODE_FW;
  // period ends when count hits zero
  assign tick    = !wait_hi && cnt == 8'h00;
  assign rise    = wait_hi && scl_s;
  assign busy    = state != S_IDLE || tx_go || (|ctrl_b[4:0]);
  assign buf_wr  = wr_in && addr_in == IMS_OFF_BUF;
  // bus start or stop seen in firmware mode
  assign fw_edge = fw_mode && scl_s && (sda_d != sda_s);

  always_comb begin
    coll = 1'b0;
    case (state)
      S_IDLE: coll = ctrl_b[IMS_B_START] && p_clr == 5'h00
                     && !scl_s && !sda_s;
      S_SA:   coll = !scl_s || (tick && !sda_s);
      S_RA:   coll = tick && !sda_s;
      S_RB:   coll = (rise && !sda_s) || (!wait_hi && (!scl_s || !sda_s));
      S_TH:   coll = !wait_hi && !sda_oe_out && !sda_s
                     && bitcnt != IMS_BITS_BYTE;
      default: coll = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // line synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else if (ce_in) begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  // ------------------------------------------------------------
  // register writes and flags
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_a          <= IMS_RST_BYTE;
      ctrl_b          <= IMS_RST_BYTE;
      buffer          <= IMS_RST_BYTE;
      rate            <= IMS_RST_RATE;
      fw_lines        <= 2'h0;
      buffer_full     <= 1'b0;
      port_event_flag <= 1'b0;
      collision_flag  <= 1'b0;
      write_collision <= 1'b0;
      tx_go           <= 1'b0;
    end else if (ce_in) begin
      tx_go <= 1'b0;
      if (wr_in && addr_in == IMS_OFF_CTRL_A) begin
        ctrl_a <= wdata_in;
      end
      if (wr_in && addr_in == IMS_OFF_RATE) begin
        rate <= wdata_in;
      end
      if (wr_in && addr_in == IMS_OFF_FWLINE) begin
        fw_lines <= wdata_in[1:0];
      end
      ctrl_b[4:0] <= ctrl_b[4:0] & ~p_clr;
      if (wr_in && addr_in == IMS_OFF_CTRL_B) begin
        ctrl_b[IMS_B_ACKVAL] <= wdata_in[IMS_B_ACKVAL];
        if (!busy && hw_mode) begin
          ctrl_b[4:0] <= wdata_in[4:0];
        end
      end
      // no queueing behind a busy sequencer
      if (buf_wr && (busy || !hw_mode)) begin
        write_collision <= 1'b1;
      end else if (buf_wr) begin
        buffer <= wdata_in;
        tx_go  <= 1'b1;
      end else if (wr_in && addr_in == IMS_OFF_FLAGS
                   && wdata_in[IMS_F_WRITE_COLLISION]) begin
        write_collision <= 1'b0;
      end
      if (p_rxload) begin
        buffer <= shreg;
      end
      // full on load, cleared by read, eighth fall or collision
      if ((buf_wr && !busy && hw_mode) || p_rxload) begin
        buffer_full <= 1'b1;
      end else if (p_bfclr || p_bcl
                   || (rd_in && addr_in == IMS_OFF_BUF)) begin
        buffer_full <= 1'b0;
      end
      // set wins over a same-cycle clear
      port_event_flag <= p_evt || fw_edge || (port_event_flag
        && !(wr_in && addr_in == IMS_OFF_FLAGS && wdata_in[IMS_F_EVENT]));
      collision_flag  <= p_bcl || (collision_flag
        && !(wr_in && addr_in == IMS_OFF_FLAGS && wdata_in[IMS_F_BUSCOL]));
    end
  end

  // ------------------------------------------------------------
  // start and stop seen
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      start_seen <= 1'b0;
      stop_seen  <= 1'b0;
    end else if (ce_in) begin
      // cleared while the port is disabled
      if (!ctrl_a[IMS_A_ENABLE]) begin
        start_seen <= 1'b0;
        stop_seen  <= 1'b0;
      // bus detection only in firmware mode
      end else if (p_sseen
                   || (fw_mode && scl_s && sda_d && !sda_s)) begin
        start_seen <= 1'b1;
        stop_seen  <= 1'b0;
      end else if (p_pseen
                   || (fw_mode && scl_s && !sda_d && sda_s)) begin
        start_seen <= 1'b0;
        stop_seen  <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // sequencer, bit period counter, line drive
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state      <= S_IDLE;
      cnt        <= IMS_RST_BYTE;
      shreg      <= IMS_RST_BYTE;
      bitcnt     <= 4'h0;
      wait_hi    <= 1'b0;
      ack_stat   <= 1'b0;
      scl_oe_out <= 1'b0;
      sda_oe_out <= 1'b0;
      p_evt      <= 1'b0;
      p_bcl      <= 1'b0;
      p_bfclr    <= 1'b0;
      p_rxload   <= 1'b0;
      p_sseen    <= 1'b0;
      p_pseen    <= 1'b0;
      p_clr      <= 5'h00;
    end else if (ce_in) begin
      p_evt    <= 1'b0;
      p_bcl    <= 1'b0;
      p_bfclr  <= 1'b0;
      p_rxload <= 1'b0;
      p_sseen  <= 1'b0;
      p_pseen  <= 1'b0;
      p_clr    <= 5'h00;
      // counter frozen while waiting for scl high
      if (!wait_hi && cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
      if (rise) begin
        wait_hi <= 1'b0;
        cnt     <= rate;
      end
      if (!hw_mode) begin
        state      <= S_IDLE;
        wait_hi    <= 1'b0;
        scl_oe_out <= fw_mode && fw_lines[0];
        sda_oe_out <= fw_mode && fw_lines[1];
      end else if (coll) begin
        state      <= S_IDLE;
        wait_hi    <= 1'b0;
        scl_oe_out <= 1'b0;
        sda_oe_out <= 1'b0;
        p_bcl      <= 1'b1;
        p_clr      <= 5'h1F;
      end else begin
        case (state)
          S_IDLE: begin
            cnt <= rate;
            if (p_clr != 5'h00) begin
              state <= S_IDLE;
            end else if (ctrl_b[IMS_B_START]) begin
              if (scl_s && sda_s) begin
                state <= S_SA;
              end
            end else if (ctrl_b[IMS_B_RESTART]) begin
              scl_oe_out <= 1'b1;
              state      <= S_RA;
            end else if (ctrl_b[IMS_B_STOP]) begin
              scl_oe_out <= 1'b1;
              state      <= S_PA;
            end else if (ctrl_b[IMS_B_RECV]) begin
              scl_oe_out <= 1'b1;
              bitcnt     <= 4'h0;
              state      <= S_RL;
            end else if (ctrl_b[IMS_B_ACKSEND]) begin
              scl_oe_out <= 1'b1;
              state      <= S_AL;
            end else if (tx_go) begin
              // address and rw bit leave msb first
              shreg      <= buffer;
              bitcnt     <= 4'h0;
              scl_oe_out <= 1'b1;
              state      <= S_TL;
            end
          end
          S_SA: if (tick) begin
            // pull sda low with scl high
            sda_oe_out <= 1'b1;
            p_sseen    <= 1'b1;
            cnt        <= rate;
            state      <= S_SB;
          end
          S_SB: if (tick) begin
            // flag raised as the request clears
            p_evt <= 1'b1;
            p_clr <= 5'h01;
            state <= S_IDLE;
          end
          S_RA: begin
            // release sda only once scl is low
            if (!scl_s) begin
              sda_oe_out <= 1'b0;
            end
            if (tick) begin
              scl_oe_out <= 1'b0;
              wait_hi    <= 1'b1;
              state      <= S_RB;
            end
          end
          S_RB: if (tick) begin
            // start seen now, flag after timeout
            sda_oe_out <= 1'b1;
            p_sseen    <= 1'b1;
            cnt        <= rate;
            state      <= S_RC;
          end
          S_RC: if (tick) begin
            scl_oe_out <= 1'b1;
            p_evt      <= 1'b1;
            p_clr      <= 5'h02;
            state      <= S_IDLE;
          end
          S_TL: begin
            // sda released for the ninth bit
            if (!scl_s) begin
              sda_oe_out <= bitcnt != IMS_BITS_BYTE && !shreg[7];
            end
            if (tick) begin
              scl_oe_out <= 1'b0;
              wait_hi    <= 1'b1;
              state      <= S_TH;
            end
          end
          S_TH: begin
            // slave ack taken as scl rises
            if (rise && bitcnt == IMS_BITS_BYTE) begin
              ack_stat <= sda_s;
            end
            if (tick) begin
              scl_oe_out <= 1'b1;
              cnt        <= rate;
              if (bitcnt == IMS_BITS_BYTE) begin
                p_evt <= 1'b1;
                state <= S_IDLE;
              end else begin
                shreg  <= {shreg[6:0], 1'b0};
                bitcnt <= bitcnt + 4'h1;
                p_bfclr <= bitcnt == 4'h7;
                state  <= S_TL;
              end
            end
          end
          S_RL: begin
            sda_oe_out <= 1'b0;
            if (tick) begin
              scl_oe_out <= 1'b0;
              wait_hi    <= 1'b1;
              state      <= S_RH;
            end
          end
          S_RH: begin
            if (rise) begin
              shreg <= {shreg[6:0], sda_s};
            end
            if (tick) begin
              scl_oe_out <= 1'b1;
              cnt        <= rate;
              bitcnt     <= bitcnt + 4'h1;
              if (bitcnt == 4'h7) begin
                p_rxload <= 1'b1;
                p_evt    <= 1'b1;
                p_clr    <= 5'h08;
                state    <= S_IDLE;
              end else begin
                state <= S_RL;
              end
            end
          end
          S_AL: begin
            if (!scl_s) begin
              sda_oe_out <= !ctrl_b[IMS_B_ACKVAL];
            end
            if (tick) begin
              scl_oe_out <= 1'b0;
              wait_hi    <= 1'b1;
              state      <= S_AH;
            end
          end
          S_AH: if (tick) begin
            scl_oe_out <= 1'b1;
            p_evt      <= 1'b1;
            p_clr      <= 5'h10;
            state      <= S_IDLE;
          end
          S_PA: begin
            // sda low first, then scl released
            if (!scl_s) begin
              sda_oe_out <= 1'b1;
            end
            if (tick) begin
              scl_oe_out <= 1'b0;
              wait_hi    <= 1'b1;
              state      <= S_PB;
            end
          end
          S_PB: if (tick) begin
            sda_oe_out <= 1'b0;
            cnt        <= rate;
            state      <= S_PC;
          end
          S_PC: begin
            // stop seen with both lines high
            p_pseen <= scl_s && sda_s && !stop_seen;
            if (tick) begin
              p_evt <= 1'b1;
              p_clr <= 5'h04;
              state <= S_IDLE;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // read data, lines held at low level
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= IMS_RST_BYTE;
      scl_out   <= 1'b0;
      sda_out   <= 1'b0;
    end else if (ce_in) begin
      scl_out   <= 1'b0;
      sda_out   <= 1'b0;
      rdata_out <= IMS_RST_BYTE;
      if (rd_in) begin
        case (addr_in)
          IMS_OFF_CTRL_A: rdata_out <= ctrl_a;
          IMS_OFF_CTRL_B: rdata_out <= {1'b0, ack_stat, ctrl_b[5:0]};
          IMS_OFF_STATUS: rdata_out <= {3'h0, stop_seen, start_seen,
                                        2'h0, buffer_full};
          IMS_OFF_BUF:    rdata_out <= buffer;
          IMS_OFF_RATE:   rdata_out <= rate;
          IMS_OFF_FLAGS:  rdata_out <= {5'h00, write_collision,
                                        collision_flag, port_event_flag};
          IMS_OFF_FWLINE: rdata_out <= {6'h00, fw_lines};
          default:        rdata_out <= IMS_RST_BYTE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  AST_EVT_SET: assert property (ce_in && p_evt |=> port_event_flag)
    else $error("event pulse did not set event flag");
  AST_WRITE_COLLISION: assert property (ce_in && buf_wr && busy
    |=> write_collision && buffer == $past(buffer))
    else $error("busy buffer write not refused");
  AST_SEEN_CLR: assert property (ce_in && !ctrl_a[IMS_A_ENABLE]
    |=> !start_seen && !stop_seen)
    else $error("seen bits not cleared when disabled");
  AST_CB_LOCK: assert property (ce_in && wr_in && addr_in == IMS_OFF_CTRL_B
    && ctrl_b[IMS_B_START] && p_clr == 5'h00
    |=> ctrl_b[4:0] == $past(ctrl_b[4:0]))
    else $error("control b changed during start");
  AST_BRG_HOLD: assert property (ce_in && wait_hi && !scl_s
    |=> cnt == $past(cnt))
    else $error("counter ran while scl low");
  AST_TX_FULL: assert property (ce_in && buf_wr && !busy && hw_mode
    |=> buffer_full ##1 state == S_TL)
    else $error("accepted write did not start transmit");
  AST_ACK_REL: assert property (state == S_TL && bitcnt == IMS_BITS_BYTE
    && ce_in && !scl_s |=> !sda_oe_out)
    else $error("sda not released for ack bit");
  AST_COLL: assert property (ce_in && hw_mode && state == S_TH && !wait_hi
    && !sda_oe_out && !sda_s && bitcnt != IMS_BITS_BYTE
    |=> state == S_IDLE && !scl_oe_out && !sda_oe_out
    ##1 collision_flag)
    else $error("arbitration loss not handled");
  AST_RX_DONE: assert property (ce_in && p_rxload
    |=> buffer_full && !ctrl_b[IMS_B_RECV])
    else $error("receive completion incomplete");
  AST_START_LOW: assert property (ce_in && hw_mode && state == S_SB
    |-> sda_oe_out && !scl_oe_out)
    else $error("start hold phase lines wrong");

  CVR_START: cover property (state == S_SB ##[1:300] state == S_IDLE);
  CVR_BYTE: cover property (state == S_TH && bitcnt == IMS_BITS_BYTE
    ##1 state == S_IDLE);
  CVR_COLL: cover property (p_bcl);
  CVR_RECV: cover property (p_rxload);
endmodule // ims_master_seq

// ### bench/ims_slave_model.sv
// two-wire slave model: byte capture, acknowledge, clock stretch
`timescale 1ns/100ps
module ims_slave_model (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  // wire levels and options
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       ack_en_in,
  input  wire logic       stretch_in,
  // pulls and captured byte
  output logic            scl_pull_out,
  output logic            sda_pull_out,
  output logic      [7:0] byte_out
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] cnt;
  logic [2:0] hold;
  // lines are only ever pulled low
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_q        <= 1'b1;
      sda_q        <= 1'b1;
      cnt          <= 4'h0;
      hold         <= 3'h0;
      scl_pull_out <= 1'b0;
      sda_pull_out <= 1'b0;
      byte_out     <= 8'h00;
    end else begin
      scl_q        <= scl_in;
      sda_q        <= sda_in;
      // stretch hides behind the master's low phase, then outlasts it
      scl_pull_out <= hold > 3'h1;
      if (hold != 3'h0) hold <= hold - 3'h1;
      if (scl_q && scl_in && sda_q != sda_in) begin
        cnt          <= 4'h0;
        sda_pull_out <= 1'b0;
      end else if (!scl_q && scl_in) begin
        if (cnt < 4'h8) byte_out <= {byte_out[6:0], sda_in};
        if (cnt < 4'h9) cnt <= cnt + 4'h1;
      end else if (scl_q && !scl_in) begin
        hold         <= stretch_in ? 3'h6 : 3'h0;
        // acknowledge driven in the ninth bit time
        sda_pull_out <= (cnt == 4'h8) && ack_en_in;
        if (cnt == 4'h9) cnt <= 4'h0;
      end
    end
  end
endmodule // ims_slave_model

// ### bench/ims_master_seq_bench.sv
// self-checking bench of the two-wire master sequencer
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
  begin \
    checks_done++; \
    if ((got) !== (ex)) begin \
      mismatches++; \
      $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
    end \
  end
module ims_master_seq_bench;
  import ims_pkg::*;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic       clk_in, rstn_in, wr_in, rd_in, ack_en, stretch, ce;
  logic [2:0] addr_in;
  logic [7:0] wdata_in, rdata_out, rb, byte_seen;
  logic       scl_oe_out, sda_oe_out, s_scl, s_sda, tb_scl, tb_sda;
  int         mismatches, checks_done, cycles;
  wire        scl = !(scl_oe_out | s_scl | tb_scl);
  wire        sda = !(sda_oe_out | s_sda | tb_sda);
  ims_master_seq dut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .scl_in(scl), .sda_in(sda), .scl_out(),
    .scl_oe_out(scl_oe_out), .sda_out(), .sda_oe_out(sda_oe_out));
  ims_slave_model slave (.clk_in(clk_in), .rstn_in(rstn_in), .scl_in(scl),
    .sda_in(sda), .ack_en_in(ack_en), .stretch_in(stretch),
    .scl_pull_out(s_scl), .sda_pull_out(s_sda), .byte_out(byte_seen));
  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    @(negedge clk_in);
    rb = rdata_out;
  endtask
  task automatic chk(input string nm, input logic [2:0] a,
                     input logic [7:0] m, input logic [7:0] e);
    rd(a);
    `CHK(nm, e, rb & m)
  endtask
  task automatic wait_flag(input int b);
    int i;
    i = 0;
    rd(IMS_OFF_FLAGS);
    while (rb[b] !== 1'b1 && i < 300) begin
      rd(IMS_OFF_FLAGS);
      i++;
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chk("rate", IMS_OFF_RATE, 8'hFF, IMS_RST_RATE);
    chk("status", IMS_OFF_STATUS, 8'hFF, 8'h00);
    chk("flags", IMS_OFF_FLAGS, 8'hFF, 8'h00);
    chk("unmapped", 3'h7, 8'hFF, 8'h00);
    @(posedge clk_in);
    ce <= 1'b0;
    wr(IMS_OFF_RATE, 8'h55);
    ce <= 1'b1;
    chk("frozen rate", IMS_OFF_RATE, 8'hFF, IMS_RST_RATE);
    $display("test reset done");
  endtask
  task automatic t_start;
    wr(IMS_OFF_CTRL_A, 8'h28);
    // long period keeps the start busy across the refused writes
    wr(IMS_OFF_RATE, 8'h0F);
    wr(IMS_OFF_CTRL_B, 8'h01);
    wr(IMS_OFF_BUF, 8'hA4);
    chk("early write_collision", IMS_OFF_FLAGS, 8'h04, 8'h04);
    wr(IMS_OFF_CTRL_B, 8'h08);
    chk("locked ctrl_b", IMS_OFF_CTRL_B, 8'h1F, 8'h01);
    wait_flag(IMS_F_EVENT);
    chk("start event", IMS_OFF_FLAGS, 8'h01, 8'h01);
    chk("start cleared", IMS_OFF_CTRL_B, 8'h01, 8'h00);
    chk("start seen", IMS_OFF_STATUS, 8'h18, 8'h08);
    `CHK("start sda held", 1'b1, sda_oe_out)
    `CHK("start scl free", 1'b0, scl_oe_out)
    chk("buf unchanged", IMS_OFF_BUF, 8'hFF, IMS_RST_BYTE);
    wr(IMS_OFF_FLAGS, 8'h07);
    chk("flags cleared", IMS_OFF_FLAGS, 8'h07, 8'h00);
    $display("test start done");
  endtask
  task automatic t_tx_ack;
    wr(IMS_OFF_RATE, 8'h03);
    wr(IMS_OFF_BUF, 8'hA4);
    chk("full set", IMS_OFF_STATUS, 8'h01, 8'h01);
    wr(IMS_OFF_BUF, 8'h55);
    wait_flag(IMS_F_EVENT);
    chk("busy write_collision", IMS_OFF_FLAGS, 8'h05, 8'h05);
    `CHK("address byte", 8'hA4, byte_seen)
    chk("ack status", IMS_OFF_CTRL_B, 8'h40, 8'h00);
    chk("full clear", IMS_OFF_STATUS, 8'h01, 8'h00);
    `CHK("scl held", 1'b1, scl_oe_out)
    `CHK("sda free", 1'b0, sda_oe_out)
    wr(IMS_OFF_FLAGS, 8'h07);
    $display("test tx ack done");
  endtask
  task automatic t_tx_nack;
    ack_en  <= 1'b0;
    stretch <= 1'b1;
    wr(IMS_OFF_BUF, 8'h3C);
    wait_flag(IMS_F_EVENT);
    `CHK("stretched byte", 8'h3C, byte_seen)
    chk("nack status", IMS_OFF_CTRL_B, 8'h40, 8'h40);
    wr(IMS_OFF_FLAGS, 8'h07);
    $display("test tx nack done");
  endtask
  task automatic t_restart;
    wr(IMS_OFF_CTRL_A, 8'h08);
    wr(IMS_OFF_CTRL_A, 8'h28);
    wr(IMS_OFF_CTRL_B, 8'h02);
    wr(IMS_OFF_CTRL_B, 8'h04);
    wait_flag(IMS_F_EVENT);
    chk("restart cleared", IMS_OFF_CTRL_B, 8'h07, 8'h00);
    chk("restart seen", IMS_OFF_STATUS, 8'h18, 8'h08);
    `CHK("restart sda", 1'b1, sda_oe_out)
    `CHK("restart scl", 1'b1, scl_oe_out)
    wr(IMS_OFF_FLAGS, 8'h07);
    $display("test restart done");
  endtask
  task automatic t_stop;
    // silent slave, receive reads the pull-up
    wr(IMS_OFF_CTRL_B, 8'h08);
    wait_flag(IMS_F_EVENT);
    chk("rx full", IMS_OFF_STATUS, 8'h01, 8'h01);
    chk("rx byte", IMS_OFF_BUF, 8'hFF, 8'hFF);
    chk("rx cleared", IMS_OFF_CTRL_B, 8'h08, 8'h00);
    wr(IMS_OFF_FLAGS, 8'h07);
    wr(IMS_OFF_CTRL_B, 8'h10);
    wait_flag(IMS_F_EVENT);
    chk("ack cleared", IMS_OFF_CTRL_B, 8'h10, 8'h00);
    `CHK("ack driven", 1'b1, sda_oe_out)
    wr(IMS_OFF_FLAGS, 8'h07);
    wr(IMS_OFF_CTRL_B, 8'h04);
    wait_flag(IMS_F_EVENT);
    chk("stop seen", IMS_OFF_STATUS, 8'h18, 8'h10);
    chk("stop cleared", IMS_OFF_CTRL_B, 8'h04, 8'h00);
    `CHK("stop lines", 2'b00, {scl_oe_out, sda_oe_out})
    wr(IMS_OFF_FLAGS, 8'h07);
    wr(IMS_OFF_CTRL_A, 8'h08);
    chk("disable seen", IMS_OFF_STATUS, 8'h18, 8'h00);
    wr(IMS_OFF_CTRL_A, 8'h28);
    $display("test stop done");
  endtask
  task automatic t_collide;
    tb_scl <= 1'b1;
    tb_sda <= 1'b1;
    repeat (4) @(posedge clk_in);
    wr(IMS_OFF_CTRL_B, 8'h01);
    wait_flag(IMS_F_BUSCOL);
    chk("start abort", IMS_OFF_FLAGS, 8'h03, 8'h02);
    chk("abort cleared", IMS_OFF_CTRL_B, 8'h01, 8'h00);
    tb_scl <= 1'b0;
    tb_sda <= 1'b0;
    wr(IMS_OFF_FLAGS, 8'h07);
    wr(IMS_OFF_CTRL_B, 8'h01);
    wait_flag(IMS_F_EVENT);
    wr(IMS_OFF_FLAGS, 8'h07);
    tb_sda <= 1'b1;
    wr(IMS_OFF_BUF, 8'hFF);
    wait_flag(IMS_F_BUSCOL);
    chk("arb lost", IMS_OFF_FLAGS, 8'h02, 8'h02);
    chk("arb full", IMS_OFF_STATUS, 8'h01, 8'h00);
    `CHK("arb lines", 2'b00, {scl_oe_out, sda_oe_out})
    tb_sda <= 1'b0;
    wr(IMS_OFF_FLAGS, 8'h07);
    $display("test collision done");
  endtask
  task automatic t_firmware;
    wr(IMS_OFF_CTRL_A, 8'h0B);
    wr(IMS_OFF_CTRL_A, 8'h2B);
    wr(IMS_OFF_FWLINE, 8'h02);
    repeat (4) @(posedge clk_in);
    chk("fw start", IMS_OFF_STATUS, 8'h18, 8'h08);
    chk("fw event", IMS_OFF_FLAGS, 8'h01, 8'h01);
    wr(IMS_OFF_FWLINE, 8'h00);
    repeat (4) @(posedge clk_in);
    chk("fw stop", IMS_OFF_STATUS, 8'h18, 8'h10);
    $display("test firmware done");
  endtask
  // ------------------------------------------------------------
  // clock, run and verdict
  // ------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // hang guard well above the few hundred cycles the run needs
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    rstn_in  = 1'b0;
    wr_in    = 1'b0;
    rd_in    = 1'b0;
    addr_in  = 3'h0;
    wdata_in = 8'h00;
    ack_en   = 1'b1;
    stretch  = 1'b0;
    ce       = 1'b1;
    tb_scl   = 1'b0;
    tb_sda   = 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_reset();
    t_start();
    t_tx_ack();
    t_tx_nack();
    t_restart();
    t_stop();
    t_collide();
    t_firmware();
    report_and_stop();
  end
endmodule // ims_master_seq_bench
